// ==== rtl/asr_defs.svh ====
// register offsets, field positions, reset values and timing counts of the serial core
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
// register byte offsets
`define ASR_RX_STAT_OFS  8'h00
`define ASR_RX_DATA_OFS  8'h04
`define ASR_TX_STAT_OFS  8'h08
`define ASR_TX_DATA_OFS  8'h0C
`define ASR_FORMAT_OFS   8'h10
`define ASR_CTRL_OFS     8'h14
`define ASR_RX_DIV_OFS   8'h18
`define ASR_TX_DIV_OFS   8'h1C
// status bit positions
`define ASR_RXS_FULL     0
`define ASR_RXS_PAR      1
`define ASR_RXS_FRM      2
`define ASR_RXS_OVR      3
`define ASR_TXS_ACCEPT   0
`define ASR_TXS_EMPTY    1
// format field positions
`define ASR_FMT_LEN_LO   0
`define ASR_FMT_PEN      2
`define ASR_FMT_ODD      3
`define ASR_FMT_STOP_LO  4
// control bit positions
`define ASR_CTRL_LOOP    0
`define ASR_CTRL_RST     1
// reset values
`define ASR_FORMAT_RST   6'h03
`define ASR_DIV_RST      16'h0081
// sample timing in sample clocks
`define ASR_TICKS_BIT    16
`define ASR_TICKS_HALF   8
`define ASR_STOP1_TICKS  6'h10
`define ASR_STOP15_TICKS 6'h18
`define ASR_STOP2_TICKS  6'h20
`endif

// ==== rtl/asr_pkg.sv ====
// types shared by the serial core
`default_nettype none
package asr_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_STOP} asr_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK} asr_rx_st_t;
endpackage
`default_nettype wire

// ==== rtl/asr_core.sv ====
// full-duplex asynchronous serial receiver and transmitter with wishbone register access
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"
module asr_core
  import asr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial line
  input  wire logic        serial_in,
  output logic             serial_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] len_mask(input logic [1:0] code);
    len_mask = 8'hFF >> (2'd3 - code);
  endfunction

  function automatic logic [3:0] len_bits(input logic [1:0] code);
    len_bits = 4'd5 + {2'b00, code};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0]  fmt_r, fmt_nxt;
  logic        loop_r, loop_nxt;
  logic [15:0] rx_div_r, rx_div_nxt, tx_div_r, tx_div_nxt;
  logic [15:0] rx_dcnt_r, rx_dcnt_nxt, tx_dcnt_r, tx_dcnt_nxt;
  asr_tx_st_t  tx_st_r, tx_st_nxt;
  logic        tx_out_r, tx_out_nxt;
  logic [3:0]  tx_ph_r, tx_ph_nxt;
  logic [3:0]  tx_rem_r, tx_rem_nxt;
  logic [5:0]  tx_stp_r, tx_stp_nxt;
  logic [8:0]  tx_sh_r, tx_sh_nxt;
  logic        txh_full_r, txh_full_nxt;
  logic [7:0]  tx_buffer_reg, tx_buffer_nxt;
  asr_rx_st_t  rx_st_r, rx_st_nxt;
  logic [3:0]  rx_ph_r, rx_ph_nxt;
  logic [3:0]  rx_cnt_r, rx_cnt_nxt;
  logic [7:0]  rx_sh_r, rx_sh_nxt;
  logic        rx_pbit_r, rx_pbit_nxt;
  logic        rx_prev_r, rx_prev_nxt;
  logic [7:0]  rx_buffer_reg, rx_buffer_nxt;
  logic        holding_reg_full, holding_full_nxt;
  logic        rx_parity_fault, rx_parity_nxt;
  logic        rx_framing_fault, rx_framing_nxt;
  logic        rx_overrun_r, rx_overrun_nxt;

  logic        req, wr, rd, line_rst, tx_load_strobe, rx_take, rx_done_ev;
  logic        tx_tick, rx_tick, rx_line, rx_space, tx_can_accept, tx_holding_empty;
  logic [7:0]  rx_char_bits;
  logic [1:0]  fmt_len;
  logic        fmt_pen, fmt_odd;
  logic [5:0]  stop_ticks;

  assign fmt_len  = fmt_r[`ASR_FMT_LEN_LO +: 2];
  assign fmt_pen  = fmt_r[`ASR_FMT_PEN];
  assign fmt_odd  = fmt_r[`ASR_FMT_ODD];

  // stop length in sample ticks
  always_comb begin
    unique case (fmt_r[`ASR_FMT_STOP_LO +: 2])
      2'd0:    stop_ticks = `ASR_STOP1_TICKS;
      2'd1:    stop_ticks = `ASR_STOP15_TICKS;
      default: stop_ticks = `ASR_STOP2_TICKS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode: answer one cycle after the request appears
  assign req           = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr            = req & wb_we_i;
  assign rd            = req & ~wb_we_i;
  assign line_rst      = wr & wb_sel_i[0] & (wb_adr_i == `ASR_CTRL_OFS) & wb_dat_i[`ASR_CTRL_RST];
  assign rx_take       = rd & (wb_adr_i == `ASR_RX_DATA_OFS);
  assign tx_can_accept = ~txh_full_r;
  assign tx_load_strobe = wr & wb_sel_i[0] & (wb_adr_i == `ASR_TX_DATA_OFS) & tx_can_accept;
  assign tx_holding_empty = (tx_st_r == TX_IDLE);
  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = rdata_r;

  // register file next values
  always_comb begin
    ack_nxt       = req;
    rdata_nxt     = rdata_r;
    fmt_nxt       = fmt_r;
    loop_nxt      = loop_r;
    rx_div_nxt    = rx_div_r;
    tx_div_nxt    = tx_div_r;
    tx_buffer_nxt = tx_buffer_reg;
    if (rd) begin
      rdata_nxt = 32'h0000_0000;
      unique case (wb_adr_i)
        `ASR_RX_STAT_OFS: rdata_nxt[3:0] = {rx_overrun_r, rx_framing_fault, rx_parity_fault, holding_reg_full};
        `ASR_RX_DATA_OFS: rdata_nxt[7:0] = rx_buffer_reg;
        `ASR_TX_STAT_OFS: rdata_nxt[1:0] = {tx_holding_empty, tx_can_accept};
        `ASR_FORMAT_OFS:  rdata_nxt[5:0] = fmt_r;
        `ASR_CTRL_OFS:    rdata_nxt[0]   = loop_r;
        `ASR_RX_DIV_OFS:  rdata_nxt[15:0] = rx_div_r;
        `ASR_TX_DIV_OFS:  rdata_nxt[15:0] = tx_div_r;
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      if (wb_sel_i[0] && wb_adr_i == `ASR_FORMAT_OFS) fmt_nxt = wb_dat_i[5:0];
      if (wb_sel_i[0] && wb_adr_i == `ASR_CTRL_OFS) loop_nxt = wb_dat_i[`ASR_CTRL_LOOP];
      if (wb_adr_i == `ASR_RX_DIV_OFS) begin
        if (wb_sel_i[0]) rx_div_nxt[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) rx_div_nxt[15:8] = wb_dat_i[15:8];
      end
      if (wb_adr_i == `ASR_TX_DIV_OFS) begin
        if (wb_sel_i[0]) tx_div_nxt[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) tx_div_nxt[15:8] = wb_dat_i[15:8];
      end
      if (tx_load_strobe) tx_buffer_nxt = wb_dat_i[7:0];
    end
  end

  // register file flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r         <= 1'b0;
      rdata_r       <= 32'h0000_0000;
      fmt_r         <= `ASR_FORMAT_RST;
      loop_r        <= 1'b0;
      rx_div_r      <= `ASR_DIV_RST;
      tx_div_r      <= `ASR_DIV_RST;
      tx_buffer_reg <= 8'h00;
    end else begin
      ack_r         <= ack_nxt;
      rdata_r       <= rdata_nxt;
      fmt_r         <= fmt_nxt;
      loop_r        <= loop_nxt;
      rx_div_r      <= rx_div_nxt;
      tx_div_r      <= tx_div_nxt;
      tx_buffer_reg <= tx_buffer_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16x sample tick generators
  assign tx_tick = (tx_dcnt_r >= tx_div_r);
  assign rx_tick = loop_r ? tx_tick : (rx_dcnt_r >= rx_div_r);

  // divider counters; restart at once when a smaller divisor is written
  always_comb begin
    tx_dcnt_nxt = (tx_dcnt_r >= tx_div_r) ? 16'h0000 : tx_dcnt_r + 16'h0001;
    rx_dcnt_nxt = (rx_dcnt_r >= rx_div_r) ? 16'h0000 : rx_dcnt_r + 16'h0001;
  end

  // divider flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_dcnt_r <= 16'h0000;
      rx_dcnt_r <= 16'h0000;
    end else begin
      tx_dcnt_r <= tx_dcnt_nxt;
      rx_dcnt_r <= rx_dcnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: holding register feeds shifter from idle on a tick, or at end of the stop bits
  assign serial_out = loop_r ? 1'b1 : tx_out_r;

  // transmit next values
  always_comb begin
    logic do_load;
    do_load      = 1'b0;
    tx_st_nxt    = tx_st_r;
    tx_out_nxt   = tx_out_r;
    tx_ph_nxt    = tx_ph_r;
    tx_rem_nxt   = tx_rem_r;
    tx_stp_nxt   = tx_stp_r;
    tx_sh_nxt    = tx_sh_r;
    txh_full_nxt = txh_full_r | tx_load_strobe;
    unique case (tx_st_r)
      TX_IDLE: begin
        tx_out_nxt = 1'b1;
        if (txh_full_r && tx_tick) do_load = 1'b1;
      end
      TX_SEND: begin
        if (tx_tick) begin
          tx_ph_nxt = tx_ph_r + 4'd1;
          if (tx_ph_r == 4'hF) begin
            if (tx_rem_r == 4'd0) begin
              tx_st_nxt  = TX_STOP;
              tx_out_nxt = 1'b1;
              tx_stp_nxt = 6'd0;
            end else begin
              tx_out_nxt = tx_sh_r[0];
              tx_sh_nxt  = tx_sh_r >> 1;
              tx_rem_nxt = tx_rem_r - 4'd1;
            end
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          tx_stp_nxt = tx_stp_r + 6'd1;
          if (tx_stp_r == stop_ticks - 6'd1) begin
            if (txh_full_r) do_load = 1'b1;
            else tx_st_nxt = TX_IDLE;
          end
        end
      end
    endcase
    // moving the holding register into the shifter frees the buffer
    if (do_load) begin
      tx_st_nxt    = TX_SEND;
      tx_out_nxt   = 1'b0;
      tx_ph_nxt    = 4'd0;
      tx_sh_nxt    = {1'b0, tx_buffer_reg & len_mask(fmt_len)}
                   | (9'((^(tx_buffer_reg & len_mask(fmt_len))) ^ fmt_odd) << len_bits(fmt_len));
      tx_rem_nxt   = len_bits(fmt_len) + {3'b000, fmt_pen};
      txh_full_nxt = 1'b0;
    end
    if (line_rst) begin
      tx_st_nxt    = TX_IDLE;
      tx_out_nxt   = 1'b1;
      txh_full_nxt = 1'b0;
    end
  end

  // transmit flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_r    <= TX_IDLE;
      tx_out_r   <= 1'b1;
      tx_ph_r    <= 4'd0;
      tx_rem_r   <= 4'd0;
      tx_stp_r   <= 6'd0;
      tx_sh_r    <= 9'h000;
      txh_full_r <= 1'b0;
    end else begin
      tx_st_r    <= tx_st_nxt;
      tx_out_r   <= tx_out_nxt;
      tx_ph_r    <= tx_ph_nxt;
      tx_rem_r   <= tx_rem_nxt;
      tx_stp_r   <= tx_stp_nxt;
      tx_sh_r    <= tx_sh_nxt;
      txh_full_r <= txh_full_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver input select and start-centre counter source
  assign rx_line      = loop_r ? tx_out_r : serial_in;
  assign rx_space     = ~rx_line;
  assign rx_char_bits = rx_sh_r >> (2'd3 - fmt_len);
  assign rx_done_ev   = (rx_st_r == RX_STOP) && rx_tick && (rx_ph_r == 4'hF);

  // receive next values
  always_comb begin
    rx_st_nxt        = rx_st_r;
    rx_ph_nxt        = rx_ph_r;
    rx_cnt_nxt       = rx_cnt_r;
    rx_sh_nxt        = rx_sh_r;
    rx_pbit_nxt      = rx_pbit_r;
    rx_prev_nxt      = rx_line;
    rx_buffer_nxt    = rx_buffer_reg;
    holding_full_nxt = holding_reg_full & ~rx_take;
    rx_parity_nxt    = rx_parity_fault;
    rx_framing_nxt   = rx_framing_fault;
    rx_overrun_nxt   = rx_overrun_r;
    unique case (rx_st_r)
      RX_IDLE: begin
        if (rx_prev_r && rx_space) begin
          rx_st_nxt = RX_START;
          rx_ph_nxt = 4'd0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          if (!rx_space) rx_st_nxt = RX_IDLE;
          else if (rx_ph_r == 4'(`ASR_TICKS_HALF - 1)) begin
            rx_st_nxt  = RX_DATA;
            rx_ph_nxt  = 4'd0;
            rx_cnt_nxt = 4'd0;
          end else rx_ph_nxt = rx_ph_r + 4'd1;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_ph_nxt = rx_ph_r + 4'd1;
          if (rx_ph_r == 4'hF) begin
            rx_sh_nxt  = {rx_line, rx_sh_r[7:1]};
            rx_cnt_nxt = rx_cnt_r + 4'd1;
            if (rx_cnt_r == len_bits(fmt_len) - 4'd1) rx_st_nxt = fmt_pen ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick) begin
          rx_ph_nxt = rx_ph_r + 4'd1;
          if (rx_ph_r == 4'hF) begin
            rx_pbit_nxt = rx_line;
            rx_st_nxt   = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_ph_nxt = rx_ph_r + 4'd1;
          if (rx_ph_r == 4'hF) begin
            rx_buffer_nxt    = rx_char_bits;
            holding_full_nxt = 1'b1;
            rx_framing_nxt   = ~rx_line;
            rx_parity_nxt    = fmt_pen & ((^{rx_char_bits, rx_pbit_r}) != fmt_odd);
            rx_overrun_nxt   = holding_reg_full;
            rx_st_nxt        = (rx_space && rx_char_bits == 8'h00) ? RX_BREAK : RX_IDLE;
          end
        end
      end
      RX_BREAK: begin
        if (rx_line) rx_st_nxt = RX_IDLE;
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    if (line_rst) begin
      rx_st_nxt        = RX_IDLE;
      holding_full_nxt = 1'b0;
      rx_parity_nxt    = 1'b0;
      rx_framing_nxt   = 1'b0;
      rx_overrun_nxt   = 1'b0;
    end
  end

  // receive flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_r          <= RX_IDLE;
      rx_ph_r          <= 4'd0;
      rx_cnt_r         <= 4'd0;
      rx_sh_r          <= 8'h00;
      rx_pbit_r        <= 1'b0;
      rx_prev_r        <= 1'b1;
      rx_buffer_reg    <= 8'h00;
      holding_reg_full <= 1'b0;
      rx_parity_fault  <= 1'b0;
      rx_framing_fault <= 1'b0;
      rx_overrun_r     <= 1'b0;
    end else begin
      rx_st_r          <= rx_st_nxt;
      rx_ph_r          <= rx_ph_nxt;
      rx_cnt_r         <= rx_cnt_nxt;
      rx_sh_r          <= rx_sh_nxt;
      rx_pbit_r        <= rx_pbit_nxt;
      rx_prev_r        <= rx_prev_nxt;
      rx_buffer_reg    <= rx_buffer_nxt;
      holding_reg_full <= holding_full_nxt;
      rx_parity_fault  <= rx_parity_nxt;
      rx_framing_fault <= rx_framing_nxt;
      rx_overrun_r     <= rx_overrun_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_tx_mark_idle;
    (tx_st_r == TX_IDLE && !loop_r) |-> serial_out;
  endproperty
  a_tx_mark_idle: assert property (p_tx_mark_idle) else $error("line not at mark while idle");

  property p_tx_bit_hold;
    (tx_st_r == TX_SEND && !(tx_tick && tx_ph_r == 4'hF) && !line_rst) |=> $stable(tx_out_r);
  endproperty
  a_tx_bit_hold: assert property (p_tx_bit_hold) else $error("bit changed before sixteen ticks");

  property p_tx_start;
    (tx_st_r == TX_IDLE && txh_full_r && tx_tick && !line_rst) |=> (!tx_out_r && tx_can_accept);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit or ready missing after load");

  property p_tx_no_gap;
    (tx_st_r == TX_STOP && tx_tick && tx_stp_r == stop_ticks - 6'd1 && txh_full_r && !line_rst)
      |=> (tx_st_r == TX_SEND && !tx_out_r);
  endproperty
  a_tx_no_gap: assert property (p_tx_no_gap) else $error("gap before queued character");

  property p_rx_noise;
    (rx_st_r == RX_START && rx_tick && rx_line && !line_rst) |=> (rx_st_r == RX_IDLE);
  endproperty
  a_rx_noise: assert property (p_rx_noise) else $error("short start not rejected");

  property p_rx_par_off;
    (rx_done_ev && !fmt_pen) |=> !rx_parity_fault;
  endproperty
  a_rx_par_off: assert property (p_rx_par_off) else $error("parity fault with parity off");

  property p_rx_overrun;
    (rx_done_ev && holding_reg_full && !line_rst) |=> (rx_overrun_r && holding_reg_full);
  endproperty
  a_rx_overrun: assert property (p_rx_overrun) else $error("overrun not flagged");

  property p_rx_frame;
    (rx_done_ev && rx_space && !line_rst) |=> rx_framing_fault;
  endproperty
  a_rx_frame: assert property (p_rx_frame) else $error("framing fault not flagged");

  property p_rx_take;
    (rx_take && !rx_done_ev) |=> (!holding_reg_full ##1 wb_ack_o == 1'b0);
  endproperty
  a_rx_take: assert property (p_rx_take) else $error("read did not clear full");

  property p_loop_quiet;
    loop_r |-> serial_out;
  endproperty
  a_loop_quiet: assert property (p_loop_quiet) else $error("line driven in loopback");

  c_rx_char: cover property (rx_done_ev && !rx_space);
  c_rx_break: cover property (rx_st_r == RX_BREAK);
  c_tx_b2b: cover property (tx_st_r == TX_STOP && tx_tick && tx_stp_r == stop_ticks - 6'd1 && txh_full_r);
  c_loop_char: cover property (loop_r && rx_done_ev);

endmodule
`default_nettype wire

// ==== verification/asr_term_model.sv ====
// serial terminal model standing on the far side of the core's line pins
`timescale 1ns/1ps
`default_nettype none
module asr_term_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input  wire logic core_clk,
  // serial line
  output logic      line_o,
  input  wire logic line_i
);
  int low_cnt;
  int high_run;
  int last_gap;
  int gap_at_start;
  ////////////////////////////////////////////////////////////////
  // start at mark, watchers cleared
  initial begin
    line_o = 1'b1;
    low_cnt = 0;
    high_run = 0;
    last_gap = 0;
    gap_at_start = 0;
  end
  // line watcher: clocks spent low, high run before each fall
  always @(posedge core_clk) begin
    if (line_i === 1'b0) begin
      low_cnt <= low_cnt + 1;
      if (high_run != 0) begin
        last_gap <= high_run;
      end
      high_run <= 0;
    end else begin
      high_run <= high_run + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  // one bit cell, entered just after an edge
  task automatic bit_out(input logic v);
    line_o <= v;
    repeat (BIT_CLKS) @(posedge core_clk);
  endtask
  // start, data lsb first, optional parity, one stop cell, then mark
  task automatic send(input logic [7:0] d, input int nbits, input bit pen, input logic pbit, input logic stopv);
    @(posedge core_clk);
    bit_out(1'b0);
    for (int i = 0; i < nbits; i++) begin
      bit_out(d[i]);
    end
    if (pen) begin
      bit_out(pbit);
    end
    bit_out(stopv);
    bit_out(1'b1);
  endtask
  // line held low for n clocks, then back to mark
  task automatic hold_low(input int n);
    @(posedge core_clk);
    line_o <= 1'b0;
    repeat (n) @(posedge core_clk);
    bit_out(1'b1);
  endtask
  // capture one frame from the core at mid-bit
  task automatic recv(output logic [7:0] d, input int nbits, input bit pen, output logic p, output logic s);
    int n;
    n = 0;
    d = 8'h00;
    p = 1'b0;
    while (line_i !== 1'b0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    // high run that ended just before this start bit
    gap_at_start = last_gap;
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CLKS) @(posedge core_clk);
      d[i] = line_i;
    end
    if (pen) begin
      repeat (BIT_CLKS) @(posedge core_clk);
      p = line_i;
    end
    repeat (BIT_CLKS) @(posedge core_clk);
    s = line_i;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_asr_core.sv ====
// self-checking bench for the serial core over wishbone and the terminal model
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"
module tb_asr_core;
  logic        core_clk;
  logic        arst_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        serial_in;
  logic        serial_out;
  logic [31:0] q;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic        p;
  logic        s;
  int          lows;
  int          cycles = 0;
  int          err_total = 0;
  int          compares = 0;
  ////////////////////////////////////////////////////////////////
  // clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;
  // design and far-side terminal
  asr_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in(serial_in), .serial_out(serial_out));
  asr_term_model #(.BIT_CLKS(16)) term_u (.core_clk(core_clk), .line_o(serial_in), .line_i(serial_out));
  ////////////////////////////////////////////////////////////////
  // closing report
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      give_verdict();
    end
  end
  // one classic wishbone cycle, held until ack
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rd_chk(`ASR_RX_STAT_OFS, 32'h0);
    rd_chk(`ASR_TX_STAT_OFS, 32'h3);
    rd_chk(`ASR_FORMAT_OFS, 32'h3);
    rd_chk(`ASR_RX_DIV_OFS, 32'h81);
    rd_chk(8'h40, 32'h0);
    wr(`ASR_RX_DIV_OFS, 32'h0);
    wr(`ASR_TX_DIV_OFS, 32'h0);
    // plain character, then read clears full
    term_u.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
    rd_chk(`ASR_RX_STAT_OFS, 32'h1);
    rd_chk(`ASR_RX_DATA_OFS, 32'hA5);
    rd_chk(`ASR_RX_STAT_OFS, 32'h0);
    // even/odd parity, good and bad
    for (int i = 0; i < 4; i++) begin
      wr(`ASR_FORMAT_OFS, (i >= 2) ? 32'hF : 32'h7);
      term_u.send(8'h35, 8, 1'b1, (^8'h35) ^ (i >= 2) ^ i[0], 1'b1);
      rd_chk(`ASR_RX_STAT_OFS, {30'h0, i[0], 1'b1});
      rd_chk(`ASR_RX_DATA_OFS, 32'h35);
    end
    wr(`ASR_FORMAT_OFS, 32'h3);
    // low stop bit
    term_u.send(8'h6C, 8, 1'b0, 1'b0, 1'b0);
    rd_chk(`ASR_RX_STAT_OFS, 32'h5);
    rd_chk(`ASR_RX_DATA_OFS, 32'h6C);
    // two characters unread
    term_u.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
    term_u.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
    rd_chk(`ASR_RX_STAT_OFS, 32'h9);
    rd_chk(`ASR_RX_DATA_OFS, 32'h22);
    // short low pulse is noise
    term_u.hold_low(4);
    repeat (100) @(posedge core_clk);
    rd_chk(`ASR_RX_STAT_OFS, 32'h8);
    // line held low: one zero character, then nothing
    term_u.hold_low(300);
    rd_chk(`ASR_RX_STAT_OFS, 32'h5);
    rd_chk(`ASR_RX_DATA_OFS, 32'h0);
    rd_chk(`ASR_RX_STAT_OFS, 32'h4);
    wr(`ASR_CTRL_OFS, 32'h2);
    rd_chk(`ASR_RX_STAT_OFS, 32'h0);
    rd_chk(`ASR_TX_STAT_OFS, 32'h3);
    // back-to-back transmit
    fork
      begin
        term_u.recv(d1, 8, 1'b0, p, s);
        term_u.recv(d2, 8, 1'b0, p, s);
      end
      begin
        wr(`ASR_TX_DATA_OFS, 32'h01);
        do xfer(`ASR_TX_STAT_OFS, 1'b0, 32'h0, q); while (q[0] !== 1'b1);
        wr(`ASR_TX_DATA_OFS, 32'h7E);
      end
    join
    chk(q, 32'h1);
    chk({24'h0, d1}, 32'h01);
    chk({24'h0, d2}, 32'h7E);
    chk({31'h0, s}, 32'h1);
    chk(term_u.gap_at_start, 16);
    repeat (16) @(posedge core_clk);
    rd_chk(`ASR_TX_STAT_OFS, 32'h3);
    // seven bits, even parity
    wr(`ASR_FORMAT_OFS, 32'h6);
    fork
      term_u.recv(d1, 7, 1'b1, p, s);
      wr(`ASR_TX_DATA_OFS, 32'h3D);
    join
    chk({24'h0, d1}, 32'h3D);
    chk({31'h0, p}, 32'h1);
    // odd parity for the loopback character, checked by the receiver
    wr(`ASR_FORMAT_OFS, 32'hF);
    repeat (40) @(posedge core_clk);
    // loopback: line stays mark, receiver sees the character
    lows = term_u.low_cnt;
    wr(`ASR_CTRL_OFS, 32'h1);
    wr(`ASR_TX_DATA_OFS, 32'h5A);
    repeat (250) @(posedge core_clk);
    chk(term_u.low_cnt - lows, 0);
    rd_chk(`ASR_RX_STAT_OFS, 32'h1);
    rd_chk(`ASR_RX_DATA_OFS, 32'h5A);
    wr(`ASR_CTRL_OFS, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
